/* hw/sfpe_pkg.sv */
// Constants for the serial flash program and erase sequencer
// Summary of operation
// - Quad page program: opcode, three address bytes, data bytes on four lines
// - Quad page program accepted only while the quad enable bit is set
// - Single-line page program: opcode, address, data all on line zero
// - Data passing the page end wraps to the start of that page
// - Over 256 data bytes: only the final 256 are programmed
// - Fewer than 256 bytes: only addressed bytes change, others untouched
// - Program runs only if select rises right on a data byte boundary
// - Valid program starts a timed cycle; write in progress high throughout
// - Write enable latch is cleared during every program or erase cycle
// - Status stays readable while busy; host polls write in progress
// - Program to a protected page is not executed
// - Sector erase clears the whole sector holding the address
// - Erase runs only if select rises right after the last address bit
// - Valid sector erase starts a timed cycle with write in progress high
// - 32KB block erase clears the whole block holding the address
// - Valid block erase starts a timed cycle with write in progress high
// - Erase of a protected area is not executed
package sfpe_pkg;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK_ERASE = 8'h52;
  localparam int ADDR_W = 24;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_AW = 8;
  localparam int SECT_AW = 12;
  localparam int BLK_AW = 15;
  localparam int PROT_AW = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_MHZ = 50;
  localparam int PROG_TIME_US = 700;
  localparam int SECT_TIME_MS = 50;
  localparam int BLK_TIME_MS = 160;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int SECT_CYCLES = SECT_TIME_MS * 1000 * CLK_MHZ;
  localparam int BLK_CYCLES = BLK_TIME_MS * 1000 * CLK_MHZ;
  localparam logic CS_IDLE = 1'b1;
endpackage

/* hw/sfpe_core.sv */
// Serial flash program and erase sequencer with its output FIFO
`timescale 1ns/1ns
module sfpe_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = sfpe_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

module sfpe_core #(
  parameter int PROG_CYCLES = sfpe_pkg::PROG_CYCLES,
  parameter int SECT_CYCLES = sfpe_pkg::SECT_CYCLES,
  parameter int BLK_CYCLES = sfpe_pkg::BLK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial link pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] io_in,
  // Status bits held elsewhere
  input wire logic quad_enable_bit,
  input wire logic [4:0] block_protect_bits,
  // Status outputs
  output logic write_in_progress,
  output logic write_enable_latch,
  // Array program stream
  output logic prog_valid,
  input wire logic prog_ready,
  output logic [23:0] prog_addr,
  output logic [7:0] prog_data,
  // Array erase request
  output logic erase_valid,
  input wire logic erase_ready,
  output logic [23:0] erase_addr,
  output logic erase_block
);
  typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DATA, ST_HOLD, ST_SKIP} sfpe_frame_e;
  typedef enum logic [1:0] {CY_IDLE, CY_DRAIN, CY_ERASE, CY_WAIT} sfpe_cycle_e;

  // Pins pass two flops before use
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [1:0] prev_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 6'h20;
      s2_q <= 6'h20;
      prev_q <= 2'h2;
    end else begin
      s1_q <= {cs_n_pin, sclk_pin, io_in};
      s2_q <= s1_q;
      prev_q <= s2_q[5:4];
    end
  end
  wire cs_n = s2_q[5];
  wire [3:0] io = s2_q[3:0];
  wire cs_fall = prev_q[1] && !cs_n;
  wire cs_rise = !prev_q[1] && cs_n;
  wire sck_rise = !cs_n && s2_q[4] && !prev_q[0];

  sfpe_frame_e fst_q;
  sfpe_cycle_e cst_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [4:0] bcnt_q;
  logic [2:0] dcnt_q;
  logic [7:0] sh_q;
  logic quad_q;
  logic [8:0] nbytes_q;
  logic [7:0] wptr_q;
  logic [7:0] pbuf [sfpe_pkg::PAGE_BYTES];
  logic [255:0] pvalid_q;
  logic wr_en_q;
  logic [23:0] timer_q;
  logic [15:0] page_q;
  logic [7:0] didx_q;

  // Shift decode, most significant bit first
  wire [7:0] op_nxt = {opc_q[6:0], io[0]};
  wire is_prog = (op_nxt == sfpe_pkg::OP_PAGE_PROG) || (op_nxt == sfpe_pkg::OP_QUAD_PROG);
  wire is_erase = (op_nxt == sfpe_pkg::OP_SECT_ERASE) || (op_nxt == sfpe_pkg::OP_BLK_ERASE);
  wire quad_ok = (op_nxt != sfpe_pkg::OP_QUAD_PROG) || quad_enable_bit;
  wire busy = cst_q != CY_IDLE;
  wire addr_ok = (is_prog && quad_ok || is_erase) && wr_en_q && !busy;
  wire [7:0] byte_nxt = quad_q ? {sh_q[3:0], io} : {sh_q[6:0], io[0]};
  wire [3:0] dsum = {1'b0, dcnt_q} + (quad_q ? 4'h4 : 4'h1);
  wire byte_done = dsum[3];

  // Protection: top or bottom run of 64KB blocks, size doubling per level
  wire [2:0] bp_lvl = block_protect_bits[2:0];
  wire [6:0] span = (bp_lvl == 3'h0) ? 7'h00 : 7'(7'h01 << (bp_lvl - 3'h1));
  wire [6:0] blk64 = {1'b0, addr_q[21:sfpe_pkg::PROT_AW]};
  wire prot = block_protect_bits[3] ? (blk64 < span) : (blk64 >= 7'h40 - span);

  // Commit only on a clean boundary at select rise
  wire start_prog = cs_rise && fst_q == ST_DATA && dcnt_q == 3'h0 && nbytes_q != 9'h000
                    && !prot;
  wire start_erase = cs_rise && fst_q == ST_HOLD && opc_q != sfpe_pkg::OP_WR_ENABLE
                     && !prot;
  wire set_latch = cs_rise && fst_q == ST_HOLD && opc_q == sfpe_pkg::OP_WR_ENABLE && !busy;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fst_q <= ST_SKIP;
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      bcnt_q <= 5'h00;
      dcnt_q <= 3'h0;
      sh_q <= 8'h00;
      quad_q <= 1'b0;
      nbytes_q <= 9'h000;
      wptr_q <= 8'h00;
    end else if (cs_fall) begin
      fst_q <= ST_OPC;
      bcnt_q <= 5'h00;
      dcnt_q <= 3'h0;
      nbytes_q <= 9'h000;
      quad_q <= 1'b0;
    end else if (sck_rise) begin
      unique case (fst_q)
        ST_OPC: begin
          opc_q <= op_nxt;
          bcnt_q <= bcnt_q + 5'h01;
          if (bcnt_q == 5'h07) begin
            bcnt_q <= 5'h00;
            quad_q <= op_nxt == sfpe_pkg::OP_QUAD_PROG;
            if (op_nxt == sfpe_pkg::OP_WR_ENABLE) begin
              fst_q <= ST_HOLD;
            end else begin
              fst_q <= addr_ok ? ST_ADDR : ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          addr_q <= {addr_q[22:0], io[0]};
          bcnt_q <= bcnt_q + 5'h01;
          if (bcnt_q == 5'h17) begin
            fst_q <= (opc_q == sfpe_pkg::OP_SECT_ERASE || opc_q == sfpe_pkg::OP_BLK_ERASE)
                     ? ST_HOLD : ST_DATA;
            wptr_q <= {addr_q[6:0], io[0]};
          end
        end
        ST_DATA: begin
          sh_q <= byte_nxt;
          dcnt_q <= dsum[2:0];
          if (byte_done) begin
            wptr_q <= wptr_q + 8'h01;
            if (nbytes_q != 9'h100) begin
              nbytes_q <= nbytes_q + 9'h001;
            end
          end
        end
        ST_HOLD: fst_q <= ST_SKIP;
        ST_SKIP: fst_q <= ST_SKIP;
      endcase
    end else if (cs_rise) begin
      fst_q <= ST_SKIP;
    end
  end

  // Page buffer: wrapping pointer keeps only the last 256 bytes
  wire pbuf_we = sck_rise && !cs_fall && fst_q == ST_DATA && byte_done;
  always_ff @(posedge sys_clk) begin
    if (pbuf_we) begin
      pbuf[wptr_q] <= byte_nxt;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pvalid_q <= '0;
    end else if (cs_fall && !busy) begin
      pvalid_q <= '0;
    end else if (pbuf_we) begin
      pvalid_q[wptr_q] <= 1'b1;
    end
  end

  // Drain the page through the FIFO, skipping untouched bytes
  logic fifo_rdy;
  logic [31:0] fifo_out;
  wire drain = cst_q == CY_DRAIN;
  wire push = drain && pvalid_q[didx_q];
  wire adv = drain && (!pvalid_q[didx_q] || fifo_rdy);
  sfpe_fifo #(
    .WIDTH(32),
    .DEPTH(sfpe_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rstn(rstn),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data({page_q, didx_q, pbuf[didx_q]}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(fifo_out)
  );
  assign prog_addr = fifo_out[31:8];
  assign prog_data = fifo_out[7:0];

  // Self-timed cycle; the array may stall the drain past the timer
  wire done = cst_q == CY_WAIT && timer_q == 24'h000000 && !prog_valid;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cst_q <= CY_IDLE;
      timer_q <= 24'h000000;
      didx_q <= 8'h00;
      page_q <= 16'h0000;
    end else begin
      if (timer_q != 24'h000000) begin
        timer_q <= timer_q - 24'h000001;
      end
      unique case (cst_q)
        CY_IDLE: begin
          didx_q <= 8'h00;
          page_q <= addr_q[23:sfpe_pkg::PAGE_AW];
          if (start_prog) begin
            cst_q <= CY_DRAIN;
            timer_q <= 24'(PROG_CYCLES - 1);
          end else if (start_erase) begin
            cst_q <= CY_ERASE;
            timer_q <= (opc_q == sfpe_pkg::OP_BLK_ERASE) ? 24'(BLK_CYCLES - 1)
                       : 24'(SECT_CYCLES - 1);
          end
        end
        CY_DRAIN: begin
          if (adv) begin
            didx_q <= didx_q + 8'h01;
            if (didx_q == 8'hFF) begin
              cst_q <= CY_WAIT;
            end
          end
        end
        CY_ERASE: begin
          if (erase_ready) begin
            cst_q <= CY_WAIT;
          end
        end
        CY_WAIT: begin
          if (done) begin
            cst_q <= CY_IDLE;
          end
        end
      endcase
    end
  end
  assign erase_valid = cst_q == CY_ERASE;
  assign erase_block = opc_q == sfpe_pkg::OP_BLK_ERASE;
  // Erase address rounded down to its sector or 32KB block
  assign erase_addr = erase_block
                      ? {addr_q[23:sfpe_pkg::BLK_AW], 15'h0000}
                      : {addr_q[23:sfpe_pkg::SECT_AW], 12'h000};

  // Latch is cleared as the cycle starts, well before it ends
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_en_q <= 1'b0;
    end else if (start_prog || start_erase) begin
      wr_en_q <= 1'b0;
    end else if (set_latch) begin
      wr_en_q <= 1'b1;
    end
  end
  assign write_enable_latch = wr_en_q;
  assign write_in_progress = busy;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_latch_clears: assert property ((start_prog || start_erase) |=> !wr_en_q && busy)
    else $error("latch not cleared at cycle start");
  a_busy_holds_prog: assert property (start_prog |=> write_in_progress [*8])
    else $error("write in progress dropped early");
  a_quad_gate: assert property ($rose(fst_q == ST_ADDR) && quad_q
    |-> $past(quad_enable_bit))
    else $error("quad program accepted without quad enable");
  a_prog_boundary: assert property (cs_rise && fst_q == ST_DATA && dcnt_q != 3'h0 |=> !busy)
    else $error("program started off a byte boundary");
  a_prog_prot: assert property (cs_rise && fst_q == ST_DATA && prot |=> !busy)
    else $error("protected page programmed");
  a_erase_hold: assert property (cs_rise && !busy && fst_q != ST_DATA
    && (fst_q != ST_HOLD || prot) |=> !busy)
    else $error("erase started off boundary or in a protected area");
  a_sect_align: assert property (erase_valid && !erase_block |-> erase_addr[11:0] == 12'h000)
    else $error("sector erase address not aligned");
  a_blk_align: assert property (erase_valid && erase_block |-> erase_addr[14:0] == 15'h0000)
    else $error("block erase address not aligned");
  a_page_stay: assert property (prog_valid |-> prog_addr[23:8] == page_q)
    else $error("program byte left its page");
  a_busy_timer: assert property ($fell(write_in_progress) |-> $past(timer_q) == 24'h000000)
    else $error("cycle ended before its time");
  a_push_valid: assert property (busy && $past(busy) |-> $stable(pvalid_q))
    else $error("page buffer marks changed during a cycle");

  c_prog: cover property (start_prog ##1 prog_valid);
  c_quad: cover property (start_prog && quad_q);
  c_wrap: cover property (pbuf_we && wptr_q == 8'hFF);
  c_erase: cover property (erase_valid && erase_ready);
endmodule

/* tb/sfpe_host.sv */
// Host model driving select, serial clock and data lines
`timescale 1ns/1ns
module sfpe_host (
  // Clock
  input wire logic sys_clk,
  // Link pins
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io = 4'h5;
  end
  // Half of the 160 ns link clock period
  task automatic half();
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic start();
    @(posedge sys_clk);
    cs_n <= 1'b0;
    half();
  endtask
  // Data changes while the link clock is low, so it is stable at the rise
  task automatic put(input logic [7:0] v, input int nb, input bit quad);
    for (int i = 0; i < nb; i++) begin
      io <= quad ? v[7-4*i -: 4] : {~io[3:1], v[7-i]};
      half();
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask
  // Released lines flip so a stale value is never mistaken for data
  task automatic stop();
    half();
    cs_n <= 1'b1;
    io <= ~io;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

/* tb/tb_top.sv */
// Testbench for the program and erase sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int P = 40;
  logic sys_clk, rstn, quad_en, prog_ready, erase_ready, hold, cs_n, sclk;
  logic [3:0] io;
  logic [4:0] bp;
  logic busy_out, latch_out, prog_valid, erase_valid, erase_block;
  logic [23:0] prog_addr, erase_addr;
  logic [7:0] prog_data;
  logic [31:0] pq[$];
  logic [24:0] eq[$];
  int err_count, n_checks;
  sfpe_host i_sfpe_host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .io(io));
  sfpe_core #(.PROG_CYCLES(P), .SECT_CYCLES(P), .BLK_CYCLES(P)) i_sfpe_core (
    .sys_clk(sys_clk), .rstn(rstn), .cs_n_pin(cs_n), .sclk_pin(sclk), .io_in(io),
    .quad_enable_bit(quad_en), .block_protect_bits(bp), .write_in_progress(busy_out),
    .write_enable_latch(latch_out), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_addr(prog_addr), .prog_data(prog_data), .erase_valid(erase_valid),
    .erase_ready(erase_ready), .erase_addr(erase_addr), .erase_block(erase_block));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Array side stalls every other cycle; the program stream stalls fully while hold is set
  always @(posedge sys_clk) begin
    prog_ready <= !hold && !prog_ready;
    erase_ready <= erase_valid && !erase_ready;
    if (prog_valid === 1'b1 && prog_ready) pq.push_back({prog_addr, prog_data});
    if (erase_valid === 1'b1 && erase_ready) eq.push_back({erase_addr, erase_block});
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Index 256 differs from index 0, so a kept early byte shows up
  function automatic logic [7:0] dval(input logic [7:0] base, input int i);
    return base + 8'(i * 17) + 8'(i >> 8);
  endfunction
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nd,
      input logic [7:0] base, input bit quad, input int tail);
    i_sfpe_host.start();
    i_sfpe_host.put(op, 8, 1'b0);
    for (int i = 0; i < 3; i++) i_sfpe_host.put(a[23-8*i -: 8], 8, 1'b0);
    for (int i = 0; i < nd; i++) i_sfpe_host.put(dval(base, i), quad ? 2 : 8, quad);
    i_sfpe_host.put(8'hC3, tail, quad);
    i_sfpe_host.stop();
  endtask
  task automatic set_latch();
    i_sfpe_host.start();
    i_sfpe_host.put(8'h06, 8, 1'b0);
    i_sfpe_host.stop();
  endtask
  // Busy time is counted from select rising; array stalls may stretch it
  task automatic outcome(input logic ok);
    int n;
    n = 8;
    #1;
    cmp(busy_out, ok);
    if (ok) begin
      cmp(latch_out, 1'b0);
      while (busy_out === 1'b1 && n < 5000) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      cmp(n >= P && n < 5000, 1'b1);
    end
  endtask
  task automatic chk_stream(input logic [23:0] a, input int nd, input logic [7:0] base);
    logic [7:0] m [256];
    bit w [256];
    logic [7:0] off;
    logic [31:0] got;
    for (int i = 0; i < nd; i++) begin
      off = a[7:0] + 8'(i);
      m[off] = dval(base, i);
      w[off] = 1'b1;
    end
    for (int k = 0; k < 256; k++) if (w[k]) begin
      got = pq.size() ? pq.pop_front() : 'x;
      cmp(got, {a[23:8], 8'(k), m[k]});
    end
    cmp(pq.size(), 0);
  endtask
  task automatic chk_erase(input logic [23:0] a, input logic blk);
    logic [24:0] got;
    cmp(eq.size(), 1);
    got = eq.size() ? eq.pop_front() : 'x;
    cmp(got, {a, blk});
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    // The tests need about 10,000 cycles; this allows twice that
    #400_000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    quad_en = 1'b0;
    bp = 5'h00;
    prog_ready = 1'b0;
    erase_ready = 1'b0;
    hold = 1'b0;
    err_count = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    frame(sfpe_pkg::OP_PAGE_PROG, 24'h0001FE, 3, 8'hAA, 1'b0, 0);
    outcome(1'b0);
    set_latch();
    cmp(latch_out, 1'b1);
    frame(sfpe_pkg::OP_PAGE_PROG, 24'h0001FE, 3, 8'hAA, 1'b0, 0);
    outcome(1'b1);
    chk_stream(24'h0001FE, 3, 8'hAA);
    set_latch();
    frame(sfpe_pkg::OP_QUAD_PROG, 24'h000410, 1, 8'h5A, 1'b1, 0);
    outcome(1'b0);
    @(posedge sys_clk);
    quad_en <= 1'b1;
    set_latch();
    hold <= 1'b1;
    frame(sfpe_pkg::OP_QUAD_PROG, 24'h000410, 258, 8'h5A, 1'b1, 0);
    fork
      begin
        repeat (60) @(posedge sys_clk);
        hold <= 1'b0;
      end
    join_none
    // A latch request while busy must be ignored and leave the page intact
    set_latch();
    outcome(1'b1);
    chk_stream(24'h000410, 258, 8'h5A);
    set_latch();
    frame(sfpe_pkg::OP_PAGE_PROG, 24'h000700, 2, 8'h11, 1'b0, 4);
    outcome(1'b0);
    set_latch();
    frame(sfpe_pkg::OP_SECT_ERASE, 24'h123456, 0, 8'h00, 1'b0, 1);
    outcome(1'b0);
    set_latch();
    frame(sfpe_pkg::OP_SECT_ERASE, 24'h123456, 0, 8'h00, 1'b0, 0);
    outcome(1'b1);
    chk_erase(24'h123000, 1'b0);
    set_latch();
    frame(sfpe_pkg::OP_BLK_ERASE, 24'h123456, 0, 8'h00, 1'b0, 0);
    outcome(1'b1);
    chk_erase(24'h120000, 1'b1);
    // Bottom run of one block protected
    @(posedge sys_clk);
    bp <= 5'h09;
    set_latch();
    frame(sfpe_pkg::OP_PAGE_PROG, 24'h000100, 1, 8'h33, 1'b0, 0);
    outcome(1'b0);
    // Top run of one block protected
    @(posedge sys_clk);
    bp <= 5'h01;
    set_latch();
    frame(sfpe_pkg::OP_SECT_ERASE, 24'h3FF000, 0, 8'h00, 1'b0, 0);
    outcome(1'b0);
    cmp(eq.size(), 0);
    tally_and_finish();
  end
endmodule
